/* rtl/sssd_top.sv */
// address strobe capture, burst counter, sleep control and data pins of the burst sram
`timescale 1ns/1ps
module sssd_top
	import sssd_pkg::*;
(
	// clock and reset
	input  wire logic              ref_clk,
	input  wire logic              arst_n,
	// address and strobes, synchronous to ref_clk
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic              proc_addr_strobe_n,
	input  wire logic              ctrl_addr_strobe_n,
	input  wire logic              burst_advance_n,
	input  wire logic              write_n,
	// chip enables, synchronous to ref_clk
	input  wire logic              chip_sel1_n,
	input  wire logic              chip_en2,
	input  wire logic              chip_sel3_n,
	// asynchronous pins and strap
	input  wire logic              out_enable_n,
	input  wire logic              sleep_req,
	input  wire logic              burst_mode,
	// data and parity lines, split into in, out and enable
	input  wire logic [DATA_W-1:0] data_lines_in,
	output logic      [DATA_W-1:0] data_lines_out,
	output logic                   data_lines_oe,
	input  wire logic [PAR_W-1:0]  parity_lines_in,
	output logic      [PAR_W-1:0]  parity_lines_out,
	output logic                   parity_lines_oe,
	// storage array read port
	output logic      [ADDR_W-1:0] arr_rd_addr,
	output logic                   arr_rd_en,
	input  wire logic [DATA_W-1:0] arr_rd_data,
	input  wire logic [PAR_W-1:0]  arr_rd_par,
	// storage array write port
	output logic                   arr_wr_en,
	output logic      [ADDR_W-1:0] arr_wr_addr,
	output logic      [DATA_W-1:0] arr_wr_data,
	output logic      [PAR_W-1:0]  arr_wr_par,
	input  wire logic              arr_wr_ready,
	// status
	output logic                   wbuf_ready,
	output logic                   wr_lost,
	output logic                   sleeping
);

	typedef struct packed {
		sssd_state_e          state;
		logic [ADDR_W-3:0]    addr_hi;
		logic [BURST_W-1:0]   burst_start;
		logic [BURST_W-1:0]   burst_cnt;
		logic                 interleave;
		logic [DATA_W-1:0]    din;
		logic [PAR_W-1:0]     pin;
		logic                 wr_pend;
		logic [ADDR_W-1:0]    wr_addr;
		logic [ADDR_W-1:0]    rd_addr;
		logic                 rd_en;
		logic                 rd_mask;
		logic [DATA_W-1:0]    dout;
		logic [PAR_W-1:0]     pout;
		logic                 out_en;
		logic                 aw_en;
		logic [WBUF_W-1:0]    aw_word;
		logic                 wbuf_rdy;
		logic                 lost;
		logic                 sleep;
	} sssd_core_s;

	sssd_core_s         s_reg;
	sssd_core_s         s_next;

	logic               oe_n_s;
	logic               sleep_s;
	logic               mode_s;
	logic               proc_take;
	logic               ctrl_take;
	logic               chip_on;
	logic               access;
	logic               is_wr;
	logic               first_rd;
	logic [BURST_W-1:0] lo;
	logic [ADDR_W-1:0]  cur_addr;

	sssd_buf_if #(.W(WBUF_W)) wbuf ();

	// asynchronous pins; the pull-down and pull-up levels are the reset values
	sssd_sync2 #(
		.W       (3),
		.RST_VAL ({RST_OE_N, RST_SLEEP, RST_MODE})
	) u_sync (
		.ref_clk  (ref_clk),
		.arst_n   (arst_n),
		.async_in ({out_enable_n, sleep_req, burst_mode}),
		.sync_out ({oe_n_s, sleep_s, mode_s})
	);

	sssd_fifo #(
		.W (WBUF_W),
		.D (WBUF_DEPTH)
	) u_wbuf (
		.ref_clk (ref_clk),
		.arst_n  (arst_n),
		.bus     (wbuf.buf_side)
	);

	// buffered writes drain whenever the array takes them and the block is awake
	assign wbuf.pop_ready  = arr_wr_ready && !sleep_s;
	assign wbuf.push_valid = s_reg.wr_pend;
	assign wbuf.push_data  = sssd_pack_wr(s_reg.wr_addr, s_reg.pin, s_reg.din);

	always_comb begin
		s_next    = s_reg;
		access    = 1'b0;
		is_wr     = 1'b0;
		first_rd  = 1'b0;
		lo        = s_reg.burst_start;
		cur_addr  = '0;

		proc_take = !proc_addr_strobe_n && !chip_sel1_n;
		ctrl_take = !ctrl_addr_strobe_n && !proc_take;
		chip_on   = !chip_sel1_n && chip_en2 && !chip_sel3_n;

		// strap follows the synchronised pin only between bursts, never mid-burst;
		// sampling it once at release would only ever see the synchroniser reset value
		if (s_reg.state == ST_DESEL) begin
			s_next.interleave = mode_s;
		end

		s_next.rd_en   = 1'b0;
		s_next.rd_mask = 1'b0;
		s_next.wr_pend = 1'b0;
		s_next.lost    = s_reg.wr_pend && !wbuf.push_ready;
		s_next.wbuf_rdy = wbuf.push_ready;

		// array write port follows the buffer head
		s_next.aw_en = wbuf.pop_valid && wbuf.pop_ready;
		if (wbuf.pop_valid && wbuf.pop_ready) begin
			s_next.aw_word = wbuf.pop_data;
		end

		// data lines sampled whenever the block is awake and not driving them
		if (!s_reg.out_en) begin
			s_next.din = data_lines_in;
			s_next.pin = parity_lines_in;
		end

		s_next.sleep = sleep_s;
		if (sleep_s) begin
			// sleep only on a sampled high, an open pin reads low through reset value
			s_next.state  = ST_SLEEP;
			s_next.out_en = 1'b0;
			s_next.din    = s_reg.din;
			s_next.pin    = s_reg.pin;
		end else begin
			if (s_reg.state == ST_SLEEP) begin
				s_next.state = ST_DESEL;
			end
			if (proc_take || ctrl_take) begin
				if (chip_on) begin
					s_next.addr_hi     = addr[ADDR_W-1:BURST_W];
					s_next.burst_start = addr[BURST_W-1:0];
					s_next.burst_cnt   = RST_BURST;
					is_wr              = ctrl_take && !write_n;
					first_rd           = !is_wr && (s_reg.state != ST_READ)
						&& (s_reg.state != ST_WRITE);
					s_next.state       = is_wr ? ST_WRITE : ST_READ;
					access             = 1'b1;
				end else begin
					s_next.state = ST_DESEL;
				end
			end else if (s_reg.state == ST_READ || s_reg.state == ST_WRITE) begin
				if (!burst_advance_n) begin
					// two-bit count wraps, so the latched upper bits never change
					s_next.burst_cnt = BURST_W'(s_reg.burst_cnt + BURST_STEP);
				end
				is_wr        = !write_n;
				s_next.state = is_wr ? ST_WRITE : ST_READ;
				access       = 1'b1;
			end

			lo       = sssd_burst_lo(s_next.burst_start, s_next.burst_cnt,
				s_next.interleave);
			cur_addr = {s_next.addr_hi, lo};

			if (access && !is_wr) begin
				s_next.rd_addr = cur_addr;
				s_next.rd_en   = 1'b1;
				s_next.rd_mask = first_rd;
			end
			if (access && is_wr) begin
				s_next.wr_pend = 1'b1;
				s_next.wr_addr = cur_addr;
				s_next.din     = data_lines_in;
				s_next.pin     = parity_lines_in;
			end

			// one registered stage: array data for the address held last edge
			if (s_reg.rd_en) begin
				s_next.dout = arr_rd_data;
				s_next.pout = arr_rd_par;
			end

			// drive only with output enable low, never on the first read beat out of deselect
			s_next.out_en = !oe_n_s && s_reg.rd_en && !s_reg.rd_mask;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			s_reg             <= '0;
			s_reg.state       <= ST_DESEL;
			s_reg.interleave  <= RST_MODE;
			s_reg.burst_cnt   <= RST_BURST;
			s_reg.burst_start <= RST_BURST;
		end else begin
			s_reg <= s_next;
		end
	end

	assign data_lines_out   = s_reg.dout;
	assign data_lines_oe    = s_reg.out_en;
	assign parity_lines_out = s_reg.pout;
	assign parity_lines_oe  = s_reg.out_en;
	assign arr_rd_addr      = s_reg.rd_addr;
	assign arr_rd_en        = s_reg.rd_en;
	assign arr_wr_en        = s_reg.aw_en;
	assign arr_wr_addr      = s_reg.aw_word[WB_ADDR_LSB +: ADDR_W];
	assign arr_wr_data      = s_reg.aw_word[WB_DATA_LSB +: DATA_W];
	assign arr_wr_par       = s_reg.aw_word[WB_PAR_LSB +: PAR_W];
	assign wbuf_ready       = s_reg.wbuf_rdy;
	assign wr_lost          = s_reg.lost;
	assign sleeping         = s_reg.sleep;

endmodule

/* rtl/sssd_pkg.sv */
// constants, types and helper functions of the strobe capture and data path block
// Overview of operation
// - Processor strobe sampled low latches the presented address.
// - Controller strobe sampled low also latches the presented address.
// - Any accepted strobe loads address bits one and zero into the burst counter.
// - With both strobes low on one edge, only the processor strobe counts.
// - Processor strobe is ignored while chip select one is high.
// - Sleep input high freezes activity while all stored contents are kept.
// - Undriven sleep input behaves as low, so the device runs normally.
// - Data lines acting as inputs are captured into a data register on the edge.
// - Read data comes from the location addressed at the previous edge.
// - Output enable low makes data and parity lines drive; the code drives them only in the clock after a read beat.
// - Output enable high floats data and parity lines for write data.
// - Advance sampled low during a burst steps to the next burst location.
// - First read clock after deselect keeps outputs off whatever output enable says.
// - Burst-order strap low selects linear, high or open selects interleaved.
package sssd_pkg;

	localparam int ADDR_W     = 18;
	localparam int DATA_W     = 32;
	localparam int PAR_W      = 4;
	localparam int BURST_W    = 2;
	localparam int WBUF_DEPTH = 32;
	localparam int WBUF_W     = ADDR_W + PAR_W + DATA_W;

	// position of the fields inside one buffered write word
	localparam int WB_DATA_LSB = 0;
	localparam int WB_PAR_LSB  = DATA_W;
	localparam int WB_ADDR_LSB = DATA_W + PAR_W;

	// values after reset, burst step and synchroniser depth
	localparam logic             RST_OE_N       = 1'b1;
	localparam logic             RST_SLEEP      = 1'b0;
	localparam logic             RST_MODE       = 1'b1;
	localparam logic [BURST_W-1:0] RST_BURST    = 2'h0;
	localparam logic [BURST_W-1:0] BURST_STEP   = 2'h1;
	localparam int               SYNC_STAGES    = 2;

	typedef enum logic [1:0] {
		ST_DESEL = 2'h0,
		ST_READ  = 2'h1,
		ST_WRITE = 2'h3,
		ST_SLEEP = 2'h2
	} sssd_state_e;

	// low address bits of the current burst beat
	function automatic logic [BURST_W-1:0] sssd_burst_lo(
		input logic [BURST_W-1:0] start,
		input logic [BURST_W-1:0] cnt,
		input logic               interleave
	);
		logic [BURST_W-1:0] lo;
		lo = interleave ? (start ^ cnt) : BURST_W'(start + cnt);
		return lo;
	endfunction

	function automatic logic [WBUF_W-1:0] sssd_pack_wr(
		input logic [ADDR_W-1:0] a,
		input logic [PAR_W-1:0]  p,
		input logic [DATA_W-1:0] d
	);
		return {a, p, d};
	endfunction

endpackage

/* rtl/sssd_buf_if.sv */
// valid/ready carrier between the core and its write buffer
`timescale 1ns/1ps
interface sssd_buf_if #(
	parameter int W = 8
);
	logic         push_valid;
	logic         push_ready;
	logic [W-1:0] push_data;
	logic         pop_valid;
	logic         pop_ready;
	logic [W-1:0] pop_data;

	modport buf_side (
		input  push_valid, push_data, pop_ready,
		output push_ready, pop_valid, pop_data
	);
	modport user_side (
		output push_valid, push_data, pop_ready,
		input  push_ready, pop_valid, pop_data
	);
endinterface

/* rtl/sssd_sync2.sv */
// two-stage synchroniser for the asynchronous pins
`timescale 1ns/1ps
module sssd_sync2
	import sssd_pkg::*;
#(
	parameter int         W       = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// clock and reset
	input  wire logic         ref_clk,
	input  wire logic         arst_n,
	// level in and out
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} sssd_sync_s;

	sssd_sync_s s_reg;
	sssd_sync_s s_next;

	always_comb begin
		s_next.meta   = async_in;
		s_next.stable = s_reg.meta;
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			s_reg <= {RST_VAL, RST_VAL};
		end else begin
			s_reg <= s_next;
		end
	end

	assign sync_out = s_reg.stable;
endmodule

/* rtl/sssd_fifo.sv */
// write buffer: valid/ready fifo with width and depth parameters
`timescale 1ns/1ps
module sssd_fifo
	import sssd_pkg::*;
#(
	parameter int W = WBUF_W,
	parameter int D = WBUF_DEPTH
) (
	// clock and reset
	input  wire logic ref_clk,
	input  wire logic arst_n,
	// both sides of the buffer
	sssd_buf_if.buf_side bus
);
	localparam int PW = $clog2(D);

	typedef struct packed {
		logic [PW-1:0] wr_ptr;
		logic [PW-1:0] rd_ptr;
		logic [PW:0]   count;
	} sssd_fifo_s;

	sssd_fifo_s   s_reg;
	sssd_fifo_s   s_next;
	logic [W-1:0] mem [D];
	logic         do_push;
	logic         do_pop;

	assign bus.push_ready = (s_reg.count != (PW+1)'(D));
	assign bus.pop_valid  = (s_reg.count != '0);
	assign bus.pop_data   = mem[s_reg.rd_ptr];

	always_comb begin
		s_next  = s_reg;
		do_push = bus.push_valid && bus.push_ready;
		do_pop  = bus.pop_valid && bus.pop_ready;
		if (do_push) begin
			s_next.wr_ptr = PW'(s_reg.wr_ptr + 1'b1);
		end
		if (do_pop) begin
			s_next.rd_ptr = PW'(s_reg.rd_ptr + 1'b1);
		end
		if (do_push && !do_pop) begin
			s_next.count = (PW+1)'(s_reg.count + 1'b1);
		end else if (do_pop && !do_push) begin
			s_next.count = (PW+1)'(s_reg.count - 1'b1);
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	// storage has no reset; only the pointers and the count define what is valid
	always_ff @(posedge ref_clk) begin
		if (do_push) begin
			mem[s_reg.wr_ptr] <= bus.push_data;
		end
	end
endmodule

/* bench/sssd_top_asserts.sv */
// concurrent checks on strobes, bursts, data pins, write port and sleep
`timescale 1ns/1ps
module sssd_top_asserts
	import sssd_pkg::*;
(
	// clock, reset and controls
	input wire logic              ref_clk, arst_n, proc_addr_strobe_n, ctrl_addr_strobe_n,
	input wire logic              burst_advance_n, write_n, chip_sel1_n, chip_en2, chip_sel3_n,
	input wire logic              out_enable_n, sleep_req, sleeping, arr_wr_ready,
	input wire logic [ADDR_W-1:0] addr, arr_rd_addr, arr_wr_addr,
	// data side
	input wire logic              data_lines_oe, parity_lines_oe, arr_rd_en, arr_wr_en,
	input wire logic [DATA_W-1:0] data_lines_in, data_lines_out, arr_rd_data, arr_wr_data
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	wire en = !chip_sel1_n && chip_en2 && !chip_sel3_n && !sleeping;
	wire pa = !proc_addr_strobe_n && en;
	wire ca = !ctrl_addr_strobe_n && proc_addr_strobe_n && en;
	wire idle = proc_addr_strobe_n && ctrl_addr_strobe_n && !sleeping;

	property p_proc_read;
		pa |=> arr_rd_en && arr_rd_addr == $past(addr);
	endproperty
	a_proc_read: assert property (p_proc_read)
		else $error("bad proc read start");
	property p_ctrl_read;
		ca && write_n |=> arr_rd_en && arr_rd_addr == $past(addr);
	endproperty
	a_ctrl_read: assert property (p_ctrl_read)
		else $error("bad ctrl read start");
	property p_sleep_quiet;
		sleeping && $past(sleeping) |-> !arr_rd_en && !arr_wr_en && !data_lines_oe;
	endproperty
	a_sleep_quiet: assert property (p_sleep_quiet)
		else $error("activity while asleep");
	property p_sleep_low;
		!sleep_req [*4] |=> !sleeping;
	endproperty
	a_sleep_low: assert property (p_sleep_low)
		else $error("asleep with request low");
	property p_write_cap;
		ca && !write_n && arr_wr_ready |-> ##3 arr_wr_en && arr_wr_data == $past(data_lines_in, 3)
			&& arr_wr_addr == $past(addr, 3);
	endproperty
	a_write_cap: assert property (p_write_cap)
		else $error("write word wrong");
	property p_pipe;
		arr_rd_en |=> data_lines_out == $past(arr_rd_data);
	endproperty
	a_pipe: assert property (p_pipe)
		else $error("read data not pipelined");
	property p_float;
		out_enable_n [*4] |=> !data_lines_oe && !parity_lines_oe;
	endproperty
	a_float: assert property (p_float)
		else $error("driving with enable high");
	property p_advance;
		arr_rd_en && !burst_advance_n && idle |=> arr_rd_addr[1:0] != $past(arr_rd_addr[1:0])
			&& arr_rd_addr[ADDR_W-1:2] == $past(arr_rd_addr[ADDR_W-1:2]);
	endproperty
	a_advance: assert property (p_advance)
		else $error("burst step wrong");
	property p_first;
		pa && !arr_rd_en && !$past(arr_rd_en) |-> ##2 !data_lines_oe;
	endproperty
	a_first: assert property (p_first)
		else $error("first beat driven");
	c_burst: cover property (arr_rd_en && !burst_advance_n);
	c_write: cover property (arr_wr_en);
	c_sleep: cover property (sleeping);
endmodule
bind sssd_top sssd_top_asserts u_chk (.ref_clk, .arst_n, .proc_addr_strobe_n,
	.ctrl_addr_strobe_n, .burst_advance_n, .write_n, .chip_sel1_n, .chip_en2, .chip_sel3_n,
	.out_enable_n, .sleep_req, .sleeping, .arr_wr_ready, .addr, .arr_rd_addr, .arr_wr_addr,
	.data_lines_oe, .parity_lines_oe, .arr_rd_en, .arr_wr_en, .data_lines_in, .data_lines_out,
	.arr_rd_data, .arr_wr_data);

/* bench/sssd_arr_model.sv */
// storage array stand-in: 16 words, combinational read, write on the edge
`timescale 1ns/1ps
module sssd_arr_model
	import sssd_pkg::*;
(
	// clock and ports
	input  wire logic              ref_clk,
	input  wire logic [ADDR_W-1:0] rd_addr,
	output logic      [DATA_W-1:0] rd_data,
	output logic      [PAR_W-1:0]  rd_par,
	input  wire logic              wr_en,
	input  wire logic [ADDR_W-1:0] wr_addr,
	input  wire logic [DATA_W-1:0] wr_data,
	input  wire logic [PAR_W-1:0]  wr_par
);
	logic [35:0] mem [16];
	initial for (int i = 0; i < 16; i++) mem[i] = {4'(i), {8{4'(i)}}};
	assign {rd_par, rd_data} = mem[rd_addr[3:0]];
	always @(posedge ref_clk) if (wr_en) mem[wr_addr[3:0]] <= {wr_par, wr_data};
endmodule

/* bench/tb_top.sv */
// self-checking bench: bursts, strobe priority, writes, buffer fill, sleep
`timescale 1ns/1ps
module tb_top
	import sssd_pkg::*;
;
	logic ref_clk = 1'b0, arst_n = 1'b0, proc_addr_strobe_n = 1'b1, ctrl_addr_strobe_n = 1'b1;
	logic burst_advance_n = 1'b1, write_n = 1'b1, chip_sel1_n = 1'b0, chip_en2 = 1'b1;
	logic chip_sel3_n = 1'b0, out_enable_n = 1'b1, sleep_req = 1'b0, burst_mode = 1'b1;
	logic arr_wr_ready = 1'b1, data_lines_oe, parity_lines_oe, arr_rd_en, arr_wr_en;
	logic wbuf_ready, wr_lost, sleeping;
	logic [ADDR_W-1:0] addr = '0, arr_rd_addr, arr_wr_addr;
	logic [DATA_W-1:0] data_lines_in, data_lines_out, arr_rd_data, arr_wr_data;
	logic [PAR_W-1:0]  parity_lines_in, parity_lines_out, arr_rd_par, arr_wr_par;
	logic [35:0]       drv = '0;
	int                num_errors = 0;
	int                checks = 0;
	assign {parity_lines_in, data_lines_in} = data_lines_oe ?
		{parity_lines_out, data_lines_out} : drv;
	always #50 ref_clk = ~ref_clk;
	sssd_top u_dut (.ref_clk, .arst_n, .addr, .proc_addr_strobe_n, .ctrl_addr_strobe_n,
		.burst_advance_n, .write_n, .chip_sel1_n, .chip_en2, .chip_sel3_n, .out_enable_n,
		.sleep_req, .burst_mode, .data_lines_in, .data_lines_out, .data_lines_oe,
		.parity_lines_in, .parity_lines_out, .parity_lines_oe, .arr_rd_addr, .arr_rd_en,
		.arr_rd_data, .arr_rd_par, .arr_wr_en, .arr_wr_addr, .arr_wr_data, .arr_wr_par,
		.arr_wr_ready, .wbuf_ready, .wr_lost, .sleeping);
	sssd_arr_model u_arr (.ref_clk, .rd_addr(arr_rd_addr), .rd_data(arr_rd_data),
		.rd_par(arr_rd_par), .wr_en(arr_wr_en), .wr_addr(arr_wr_addr),
		.wr_data(arr_wr_data), .wr_par(arr_wr_par));

	task automatic test_done();
		if (num_errors == 0 && checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [35:0] got, input logic [35:0] exp);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	function automatic logic [35:0] pat(input int i);
		return {4'(i), {8{4'(i)}}};
	endfunction
	task automatic tick(input int n = 1);
		repeat (n) @(negedge ref_clk);
	endtask
	task automatic strobe(input logic p, input logic c, input logic w, input logic [17:0] a);
		proc_addr_strobe_n = p;
		ctrl_addr_strobe_n = c;
		write_n = w;
		addr = a;
		tick();
		proc_addr_strobe_n = 1'b1;
		ctrl_addr_strobe_n = 1'b1;
		write_n = 1'b1;
		chip_en2 = 1'b1;
	endtask
	task automatic desel();
		chip_en2 = 1'b0;
		strobe(1'b1, 1'b0, 1'b1, 18'h0);
	endtask
	// read burst from start 1, strap and output enable as given
	task automatic t_burst(input logic m, input logic oe);
		logic [1:0] lo, pl;
		out_enable_n = oe;
		arst_n = 1'b0;
		burst_mode = m;
		tick(16);
		arst_n = 1'b1;
		tick(3);
		strobe(1'b0, 1'b1, 1'b1, 18'h2a5);
		burst_advance_n = 1'b0;
		for (int i = 0; i < 5; i++) begin
			lo = m ? 2'(1 ^ i) : 2'(1 + i);
			if (i < 4) chk(36'(arr_rd_addr), 36'({16'h00a9, lo}));
			if (i > 0) chk({parity_lines_out, data_lines_out}, pat(4 + pl));
			if (i > 0) chk(36'({data_lines_oe, parity_lines_oe}), {34'h0, {2{i > 1 && !oe}}});
			if (i == 3) begin
				burst_advance_n = 1'b1;
				chip_en2 = 1'b0;
				ctrl_addr_strobe_n = 1'b0;
			end
			pl = lo;
			tick();
			chip_en2 = 1'b1;
			ctrl_addr_strobe_n = 1'b1;
		end
	endtask
	task automatic t_prio();
		strobe(1'b1, 1'b0, 1'b1, 18'h00c);
		chk(36'({arr_rd_en, arr_rd_addr}), 36'({1'b1, 18'h00c}));
		strobe(1'b0, 1'b0, 1'b0, 18'h013);
		chk(36'({arr_rd_en, arr_rd_addr}), 36'({1'b1, 18'h013}));
		chip_sel1_n = 1'b1;
		strobe(1'b0, 1'b1, 1'b1, 18'h020);
		chip_sel1_n = 1'b0;
		chk(36'(arr_rd_addr), 36'h13);
		desel();
	endtask
	task automatic t_write();
		out_enable_n = 1'b1;
		tick(3);
		drv = 36'h9c3c35a5a;
		strobe(1'b1, 1'b0, 1'b0, 18'h007);
		desel();
		drv = ~drv;
		out_enable_n = 1'b0;
		tick(4);
		strobe(1'b0, 1'b1, 1'b1, 18'h007);
		desel();
		chk({parity_lines_out, data_lines_out}, 36'h9c3c35a5a);
	endtask
	// 34 writes into a stalled buffer of 32, then drain
	task automatic t_fill();
		int lost = 0;
		int wrs = 0;
		arr_wr_ready = 1'b0;
		out_enable_n = 1'b1;
		for (int i = 0; i < 34; i++) begin
			drv = pat(i);
			strobe(1'b1, 1'b0, 1'b0, 18'(i));
			lost += int'(wr_lost);
		end
		desel();
		repeat (3) begin
			lost += int'(wr_lost);
			tick();
		end
		chk(36'({wbuf_ready, lost[3:0]}), 36'h2);
		arr_wr_ready = 1'b1;
		repeat (40) begin
			tick();
			wrs += int'(arr_wr_en);
		end
		chk(36'({wbuf_ready, wrs[7:0]}), 36'h120);
	endtask
	task automatic t_sleep();
		sleep_req = 1'b1;
		tick(4);
		strobe(1'b0, 1'b1, 1'b1, 18'h003);
		tick();
		chk(36'({sleeping, arr_rd_en, data_lines_oe}), 36'h4);
		sleep_req = 1'b0;
		tick(5);
		strobe(1'b0, 1'b1, 1'b1, 18'h006);
		chk(36'({sleeping, arr_rd_en, arr_rd_addr}), 36'({2'b01, 18'h006}));
		desel();
	endtask

	initial begin
		t_burst(1'b1, 1'b0);
		t_burst(1'b0, 1'b0);
		t_burst(1'b1, 1'b1);
		t_prio();
		t_write();
		t_fill();
		t_sleep();
		test_done();
	end
	initial begin
		#100000;
		num_errors++;
		test_done();
	end
endmodule
